// ### xie_pkg.sv
/*
 * Constants, types and decode helpers for the XOR instruction executor.
 * Assumes a 16-bit instruction word, an 8-bit data path and a 14-bit
 * data address built from a 6-bit bank select and an 8-bit file address.
 */
package xie_pkg;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int unsigned INSTR_W = 16;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned BANK_W = 6;
    localparam int unsigned ADDR_W = 14;

    // ------------------------------------------------------------------
    // opcode fields
    // ------------------------------------------------------------------
    localparam logic [7:0] OPC_LIT = 8'h0A;    // upper byte 0000 1010
    localparam logic [5:0] OPC_FILE = 6'h06;   // upper bits 0001 10
    localparam int unsigned POS_DEST = 9;
    localparam int unsigned POS_ACC = 8;

    // ------------------------------------------------------------------
    // addressing constants and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] ACC_SPLIT = 8'h60;  // first address of upper 160 bytes
    localparam logic [7:0] IDX_LIMIT = 8'h5F;  // highest indexed offset
    localparam logic [BANK_W-1:0] ACC_LO_BANK = 6'h00;
    localparam logic [BANK_W-1:0] ACC_HI_BANK = 6'h3F;
    localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
    localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RST = 14'h0000;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        XIE_OP_NONE,
        XIE_OP_LIT,
        XIE_OP_FILE
    } xie_op_t;

    typedef enum logic [1:0] {
        XIE_Q_IDLE_OR_Q1,
        XIE_Q2_READ,
        XIE_Q3_PROC,
        XIE_Q4_WRITE
    } xie_state_t;

    typedef struct packed {
        xie_op_t op;
        logic dest;
        logic access;
        logic [7:0] field;             // literal or file address
    } xie_dec_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic rd_en;
        logic wr_en;
        logic [DATA_W-1:0] wdata;
    } xie_file_req_t;

    // ------------------------------------------------------------------
    // decode one instruction word
    // ------------------------------------------------------------------
    function automatic xie_dec_t xie_decode(input logic [INSTR_W-1:0] w);
        xie_dec_t d;
        d.op = XIE_OP_NONE;
        d.dest = w[POS_DEST];
        d.access = w[POS_ACC];
        d.field = w[7:0];
        if (w[15:8] == OPC_LIT) begin
            d.op = XIE_OP_LIT;
        end else if (w[15:10] == OPC_FILE) begin
            d.op = XIE_OP_FILE;
        end
        return d;
    endfunction

    // sign and zero of a result
    function automatic logic [1:0] xie_flags(input logic [DATA_W-1:0] r);
        return {r[DATA_W-1], r == DATA_ZERO};
    endfunction

endpackage

// ### xie_addr_map.sv
/*
 * Data address former for the file-register operand.
 * Assumes all inputs are stable for the cycle in which the address is
 * sampled; purely combinational.
 */
`timescale 1ns/1ps

module xie_addr_map (
    // operand fields
    input wire logic [7:0] field_i,
    input wire logic access_i,
    // addressing context
    input wire logic [xie_pkg::BANK_W-1:0] bank_select_reg_i,
    input wire logic ext_active_i,
    input wire logic [xie_pkg::ADDR_W-1:0] index_base_i,
    // result
    output logic [xie_pkg::ADDR_W-1:0] addr_o,
    output logic indexed_o
);

    // ------------------------------------------------------------------
    // bank choice and indexed offset
    // ------------------------------------------------------------------
    always_comb begin
        indexed_o = 1'b0;
        if (access_i) begin
            addr_o = {bank_select_reg_i, field_i};
        end else if (ext_active_i && field_i <= xie_pkg::IDX_LIMIT) begin
            indexed_o = 1'b1;
            addr_o = xie_pkg::ADDR_W'(index_base_i + {6'h00, field_i});
        end else if (field_i < xie_pkg::ACC_SPLIT) begin
            addr_o = {xie_pkg::ACC_LO_BANK, field_i};
        end else begin
            addr_o = {xie_pkg::ACC_HI_BANK, field_i};
        end
    end

endmodule

// ### xie_xor_exec.sv
/*
 * Executes the literal XOR and file XOR instructions in one four-phase
 * instruction cycle: decode, operand read, process, write.
 * Assumes a single clock, inputs synchronous to it, and a file memory
 * that answers a read in the same clock as its address.
 */
`timescale 1ns/1ps

module xie_xor_exec (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // instruction stream
    input wire logic instr_valid_i,
    input wire logic [xie_pkg::INSTR_W-1:0] instr_i,
    output logic instr_ready_o,
    // configuration and addressing context
    input wire logic extended_set_enable_i,
    input wire logic [xie_pkg::BANK_W-1:0] bank_select_reg_i,
    input wire logic [xie_pkg::ADDR_W-1:0] index_base_i,
    // file register port
    input wire logic [xie_pkg::DATA_W-1:0] file_rd_data_i,
    output xie_pkg::xie_file_req_t file_req_o,
    // core state
    output logic [xie_pkg::DATA_W-1:0] acc_o,
    output logic neg_flag_o,
    output logic zero_flag_o
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    xie_pkg::xie_state_t state, next_state;
    xie_pkg::xie_dec_t dec, next_dec;
    xie_pkg::xie_file_req_t file_req, next_file_req;
    logic [xie_pkg::DATA_W-1:0] operand, next_operand;
    logic [xie_pkg::DATA_W-1:0] result, next_result;
    logic [xie_pkg::DATA_W-1:0] acc, next_acc;
    logic neg, next_neg, zero, next_zero;
    logic ext_active, next_ext_active;
    logic [xie_pkg::ADDR_W-1:0] map_addr;
    logic map_indexed;
    logic take;

    // instruction accepted only in idle or first phase, never dropped
    assign instr_ready_o = (state == xie_pkg::XIE_Q_IDLE_OR_Q1);
    assign take = instr_valid_i && instr_ready_o;
    assign file_req_o = file_req;
    assign acc_o = acc;
    assign neg_flag_o = neg;
    assign zero_flag_o = zero;

    // ------------------------------------------------------------------
    // operand address
    // ------------------------------------------------------------------
    xie_addr_map u_addr_map (
        .field_i(dec.field),
        .access_i(dec.access),
        .bank_select_reg_i(bank_select_reg_i),
        .ext_active_i(ext_active),
        .index_base_i(index_base_i),
        .addr_o(map_addr),
        .indexed_o(map_indexed)
    );

    // ------------------------------------------------------------------
    // next values of phase sequencer and data path
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_dec = dec;
        next_file_req = file_req;
        next_file_req.rd_en = 1'b0;
        next_file_req.wr_en = 1'b0;
        next_operand = operand;
        next_result = result;
        next_acc = acc;
        next_neg = neg;
        next_zero = zero;
        next_ext_active = extended_set_enable_i;
        unique case (state)
            xie_pkg::XIE_Q_IDLE_OR_Q1: begin
                if (take) begin
                    next_dec = xie_pkg::xie_decode(instr_i);
                    next_state = xie_pkg::XIE_Q2_READ;
                end
            end
            xie_pkg::XIE_Q2_READ: begin
                // decode phase done: present the operand address
                if (dec.op == xie_pkg::XIE_OP_FILE) begin
                    next_file_req.addr = map_addr;
                    next_file_req.rd_en = 1'b1;
                end
                next_state = xie_pkg::XIE_Q3_PROC;
            end
            xie_pkg::XIE_Q3_PROC: begin
                // operand read phase
                if (dec.op == xie_pkg::XIE_OP_FILE) begin
                    next_operand = file_rd_data_i;
                end else begin
                    next_operand = dec.field;
                end
                next_state = xie_pkg::XIE_Q4_WRITE;
            end
            xie_pkg::XIE_Q4_WRITE: begin
                // process phase, then write phase
                next_result = acc ^ operand;
                if (dec.op == xie_pkg::XIE_OP_FILE && dec.dest) begin
                    next_file_req.wr_en = 1'b1;
                    next_file_req.wdata = acc ^ operand;
                end
                next_state = xie_pkg::XIE_Q_IDLE_OR_Q1;
            end
        endcase
        // idle or first phase after the write phase commits flags, and the accumulator unless a file xor writes to the file
        if (state == xie_pkg::XIE_Q_IDLE_OR_Q1 &&
            dec.op != xie_pkg::XIE_OP_NONE) begin
            if (dec.op == xie_pkg::XIE_OP_LIT || !dec.dest) begin
                next_acc = result;
            end
            {next_neg, next_zero} = xie_pkg::xie_flags(result);
            next_dec.op = xie_pkg::XIE_OP_NONE;
            if (take) begin
                next_dec = xie_pkg::xie_decode(instr_i);
            end
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state <= xie_pkg::XIE_Q_IDLE_OR_Q1;
            dec <= '{op: xie_pkg::XIE_OP_NONE, dest: 1'b0, access: 1'b0,
                     field: xie_pkg::DATA_ZERO};
            file_req <= '{addr: xie_pkg::ADDR_RST, rd_en: 1'b0,
                          wr_en: 1'b0, wdata: xie_pkg::DATA_ZERO};
            operand <= xie_pkg::DATA_ZERO;
            result <= xie_pkg::DATA_ZERO;
            acc <= xie_pkg::ACC_RST;
            neg <= 1'b0;
            zero <= 1'b0;
            ext_active <= 1'b0;
        end else begin
            state <= next_state;
            dec <= next_dec;
            file_req <= next_file_req;
            operand <= next_operand;
            result <= next_result;
            acc <= next_acc;
            neg <= next_neg;
            zero <= next_zero;
            ext_active <= next_ext_active;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    property p_lit_acc;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (state == xie_pkg::XIE_Q4_WRITE && dec.op == xie_pkg::XIE_OP_LIT)
        |=> ##1 acc == ($past(acc, 2) ^ $past(dec.field, 2));
    endproperty
    a_lit_acc: assert property (p_lit_acc)
        else $error("literal xor gave wrong accumulator");

    property p_flags;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (state == xie_pkg::XIE_Q4_WRITE && dec.op != xie_pkg::XIE_OP_NONE)
        |=> ##1 neg == $past(result[xie_pkg::DATA_W-1]) &&
            zero == ($past(result) == xie_pkg::DATA_ZERO);
    endproperty
    a_flags: assert property (p_flags)
        else $error("negative or zero flag wrong");

    property p_cycle;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        take |=> state == xie_pkg::XIE_Q2_READ ##1
                 state == xie_pkg::XIE_Q3_PROC ##1
                 state == xie_pkg::XIE_Q4_WRITE ##1 instr_ready_o;
    endproperty
    a_cycle: assert property (p_cycle)
        else $error("instruction did not finish in four phases");

    property p_lit_decode;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (take && instr_i[15:8] == xie_pkg::OPC_LIT)
        |=> dec.op == xie_pkg::XIE_OP_LIT && dec.field == $past(instr_i[7:0]);
    endproperty
    a_lit_decode: assert property (p_lit_decode)
        else $error("literal xor not recognised");

    property p_file_read;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (state == xie_pkg::XIE_Q3_PROC && dec.op == xie_pkg::XIE_OP_FILE)
        |-> file_req.rd_en ##1 operand == $past(file_rd_data_i);
    endproperty
    a_file_read: assert property (p_file_read)
        else $error("file operand not read");

    property p_dest;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (state == xie_pkg::XIE_Q4_WRITE && dec.op == xie_pkg::XIE_OP_FILE)
        |=> (file_req.wr_en == $past(dec.dest)) ##1
            (acc == ($past(dec.dest, 2) ? $past(acc, 2) : $past(result)));
    endproperty
    a_dest: assert property (p_dest)
        else $error("xor result went to wrong destination");

    property p_bank;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (state == xie_pkg::XIE_Q2_READ && dec.op == xie_pkg::XIE_OP_FILE &&
         dec.access)
        |=> file_req.addr == {$past(bank_select_reg_i), $past(dec.field)};
    endproperty
    a_bank: assert property (p_bank)
        else $error("bank select not used for address");

    property p_indexed;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (state == xie_pkg::XIE_Q2_READ && dec.op == xie_pkg::XIE_OP_FILE &&
         !dec.access && ext_active && dec.field <= xie_pkg::IDX_LIMIT)
        |=> file_req.addr == xie_pkg::ADDR_W'($past(index_base_i) +
            {xie_pkg::ACC_LO_BANK, $past(dec.field)});
    endproperty
    a_indexed: assert property (p_indexed)
        else $error("indexed offset not applied");

    property p_ext_off;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        map_indexed == (!dec.access && !$past(sys_rst_i) &&
            $past(extended_set_enable_i) && dec.field <= xie_pkg::IDX_LIMIT);
    endproperty
    a_ext_off: assert property (p_ext_off)
        else $error("indexed mode does not follow extended set");

    property p_write_phase;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        ($changed(acc) || file_req.wr_en) |-> $past(state) ==
            (file_req.wr_en ? xie_pkg::XIE_Q4_WRITE
                            : xie_pkg::XIE_Q_IDLE_OR_Q1);
    endproperty
    a_write_phase: assert property (p_write_phase)
        else $error("write outside final phase");

    c_lit: cover property (@(posedge clk_sys_i)
        take && instr_i[15:8] == xie_pkg::OPC_LIT);
    c_file_to_file: cover property (@(posedge clk_sys_i) file_req.wr_en);
    c_indexed: cover property (@(posedge clk_sys_i)
        map_indexed && state == xie_pkg::XIE_Q2_READ);
    c_back_to_back: cover property (@(posedge clk_sys_i)
        take && dec.op != xie_pkg::XIE_OP_NONE);

endmodule

// ### xor_instruction_exec_test.sv
/*
 * Self-checking bench for the XOR instruction executor.
 * Assumes the executor answers one instruction per four clocks and that
 * the file memory is modelled here with a combinational read.
 */
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin \
bad_count++; $display("FAIL %s expected %0h seen %0h", nm, exp, got); end end

module xor_instruction_exec_test;
    // ------------------------------------------------------------------
    // stimulus, memory model and bookkeeping
    // ------------------------------------------------------------------
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic instr_valid_i = 1'b0;
    logic [15:0] instr_i = 16'h0000;
    logic instr_ready_o;
    logic extended_set_enable_i = 1'b0;
    logic [5:0] bank_select_reg_i = 6'h00;
    logic [13:0] index_base_i = 14'h0000;
    logic [7:0] file_rd_data_i;
    xie_pkg::xie_file_req_t file_req_o;
    logic [7:0] acc_o;
    logic neg_flag_o;
    logic zero_flag_o;
    logic [7:0] mem [0:16383];
    logic [7:0] acc_exp = 8'h00;
    logic [13:0] rd_addr;
    logic [13:0] wr_addr;
    int rd_at;
    int wr_at;
    int ready_lo;
    int bad_count = 0;
    int checks_done = 0;

    always #25 clk_sys_i = ~clk_sys_i;

    // read data valid only under the read strobe, scrambled otherwise
    assign file_rd_data_i = (file_req_o.rd_en === 1'b1) ?
        mem[file_req_o.addr] : ~mem[file_req_o.addr];

    // file memory takes the write pulse
    always @(posedge clk_sys_i) begin
        if (file_req_o.wr_en === 1'b1) begin
            mem[file_req_o.addr] <= file_req_o.wdata;
        end
    end

    xie_xor_exec u_dut (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .instr_valid_i(instr_valid_i),
        .instr_i(instr_i),
        .instr_ready_o(instr_ready_o),
        .extended_set_enable_i(extended_set_enable_i),
        .bank_select_reg_i(bank_select_reg_i),
        .index_base_i(index_base_i),
        .file_rd_data_i(file_rd_data_i),
        .file_req_o(file_req_o),
        .acc_o(acc_o),
        .neg_flag_o(neg_flag_o),
        .zero_flag_o(zero_flag_o)
    );

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // one instruction, then log strobes over the five following cycles
    task automatic run(input logic [15:0] w);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        instr_valid_i <= 1'b1;
        instr_i <= w;
        @(negedge clk_sys_i);
        while (instr_ready_o !== 1'b1 && n < 20) begin
            @(negedge clk_sys_i);
            n++;
        end
        if (n >= 20) begin
            bad_count++;
            $display("FAIL ready wait expected 1 seen 0");
            finish_test();
        end
        @(posedge clk_sys_i);
        instr_valid_i <= 1'b0;
        rd_at = 0;
        wr_at = 0;
        ready_lo = 0;
        for (int k = 1; k <= 5; k++) begin
            @(negedge clk_sys_i);
            if (file_req_o.rd_en === 1'b1) begin
                rd_at = k;
                rd_addr = file_req_o.addr;
            end
            if (file_req_o.wr_en === 1'b1) begin
                wr_at = k;
                wr_addr = file_req_o.addr;
            end
            if (instr_ready_o === 1'b0) ready_lo++;
        end
    endtask

    // file xor with expected effective address
    task automatic xf(input logic d, input logic a, input logic [7:0] f,
                      input logic [13:0] ea);
        logic [7:0] a0;
        logic [7:0] m;
        logic [7:0] r;
        a0 = acc_exp;
        m = mem[ea];
        r = a0 ^ m;
        run({6'h06, d, a, f});
        `CHK("read addr", ea, rd_addr)
        `CHK("read cycle", 2, rd_at)
        `CHK("neg", r[7], neg_flag_o)
        `CHK("zero", (r == 8'h00), zero_flag_o)
        if (d) begin
            `CHK("file result", r, mem[ea])
            `CHK("write addr", ea, wr_addr)
            `CHK("write cycle", 4, wr_at)
            `CHK("acc kept", a0, acc_o)
        end else begin
            acc_exp = r;
            `CHK("acc result", r, acc_o)
            `CHK("no write", 0, wr_at)
            `CHK("file kept", m, mem[ea])
        end
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        `CHK("acc reset", 8'h00, acc_o)
        `CHK("flags reset", 2'b00, {neg_flag_o, zero_flag_o})
        `CHK("ready reset", 1'b1, instr_ready_o)
        `CHK("req reset", 1'b0, file_req_o.rd_en | file_req_o.wr_en)
    endtask

    task automatic t_literal();
        logic [7:0] k [3];
        k = '{8'hB5, 8'hAF, 8'h1A};
        foreach (k[i]) begin
            acc_exp = acc_exp ^ k[i];
            run({8'h0A, k[i]});
            `CHK("lit acc", acc_exp, acc_o)
            `CHK("lit neg", acc_exp[7], neg_flag_o)
            `CHK("lit zero", (acc_exp == 8'h00), zero_flag_o)
            `CHK("lit no read", 0, rd_at)
            `CHK("lit no write", 0, wr_at)
            `CHK("busy cycles", 3, ready_lo)
        end
    endtask

    // second literal waits for ready, taken in the commit phase of first
    task automatic t_back_to_back();
        logic [7:0] a0;
        a0 = acc_exp;
        @(posedge clk_sys_i);
        instr_valid_i <= 1'b1;
        instr_i <= {xie_pkg::OPC_LIT, 8'h3C};
        @(posedge clk_sys_i);
        instr_i <= {xie_pkg::OPC_LIT, 8'h5A};
        repeat (4) @(posedge clk_sys_i);
        instr_valid_i <= 1'b0;
        @(negedge clk_sys_i);
        `CHK("b2b first", a0 ^ 8'h3C, acc_o)
        repeat (4) @(negedge clk_sys_i);
        acc_exp = a0 ^ 8'h3C ^ 8'h5A;
        `CHK("b2b second", acc_exp, acc_o)
        `CHK("b2b zero", (acc_exp == 8'h00), zero_flag_o)
    endtask

    task automatic t_banked();
        @(posedge clk_sys_i);
        bank_select_reg_i <= 6'h05;
        xf(1'b0, 1'b1, 8'h33, {6'h05, 8'h33});
        xf(1'b1, 1'b1, 8'hC4, {6'h05, 8'hC4});
        @(posedge clk_sys_i);
        bank_select_reg_i <= 6'h2A;
        xf(1'b1, 1'b1, 8'h00, {6'h2A, 8'h00});
    endtask

    task automatic t_access();
        xf(1'b0, 1'b0, 8'h20, 14'h0020);
        xf(1'b1, 1'b0, 8'h5F, 14'h005F);
        xf(1'b0, 1'b0, 8'h60, {6'h3F, 8'h60});
        xf(1'b1, 1'b0, 8'hFF, 14'h3FFF);
    endtask

    task automatic t_extended();
        @(posedge clk_sys_i);
        extended_set_enable_i <= 1'b1;
        index_base_i <= 14'h1230;
        repeat (2) @(posedge clk_sys_i);
        xf(1'b0, 1'b0, 8'h5F, 14'h128F);
        xf(1'b1, 1'b0, 8'h00, 14'h1230);
        xf(1'b0, 1'b0, 8'h60, {6'h3F, 8'h60});
        xf(1'b1, 1'b1, 8'h10, {6'h2A, 8'h10});
        @(posedge clk_sys_i);
        index_base_i <= 14'h3FF0;
        xf(1'b0, 1'b0, 8'h5F, 14'h004F);
        @(posedge clk_sys_i);
        extended_set_enable_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        xf(1'b0, 1'b0, 8'h10, 14'h0010);
    endtask

    task automatic t_non_xor();
        logic [15:0] w [3];
        logic [1:0] fl;
        w = '{16'h0B12, 16'h1C12, 16'h0000};
        foreach (w[i]) begin
            fl = {neg_flag_o, zero_flag_o};
            run(w[i]);
            `CHK("nop acc", acc_exp, acc_o)
            `CHK("nop flags", fl, {neg_flag_o, zero_flag_o})
            `CHK("nop read", 0, rd_at)
            `CHK("nop write", 0, wr_at)
        end
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        for (int i = 0; i < 16384; i++) begin
            mem[i] = i[7:0] ^ {i[13:8], 2'b11};
        end
        repeat (20) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        @(negedge clk_sys_i);
        t_reset();
        t_literal();
        t_back_to_back();
        t_banked();
        t_access();
        t_extended();
        t_non_xor();
        finish_test();
    end
endmodule
